// ---- verilog/uebm_core.sv ----
// How it works
// - Bulk in sent when not busy; on ACK flip toggle, set busy, interrupt.
// - In token on a busy bulk endpoint gets a NAK and no data.
// - In token on a stalled endpoint gets a STALL.
// - No handshake after bulk data leaves state alone for a resend.
// - Double-buffered bulk in reads X on toggle 0, Y on toggle 1.
// - Endpoints 1 to 7 each direction may be isochronous.
// - Isochronous endpoints always use separate X and Y buffers.
// - Four streaming channels serve isochronous endpoints not handled by firmware.
// - Iso out packet stores sample count and sets that buffer's busy flag.
// - Isochronous endpoints never raise the endpoint interrupt.
// - Iso out buffer overflow sets the endpoint overflow bit.
// - Out channel takes count of a busy buffer, clears flag, streams samples.
// - Out channel streams nothing when the buffer is not busy.
// - In channel fills buffer in frame; at frame end writes count, clears busy.
// - In channel overflow sets the endpoint overflow bit.
// - Iso in token sends stored samples when not busy, then sets busy.
// - Iso in token on a busy buffer sends a zero-length packet.
`timescale 1ns/100ps
`default_nettype none
module uebm_core #(
  parameter int         NEP     = 8,
  parameter int         NCH     = 4,
  parameter logic [7:0] SMP_MAX = uebm_pkg::SMP_MAX_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  tok_valid,
  input  wire logic                  tok_in,
  input  wire logic [2:0]            tok_ep,
  input  wire logic                  tx_end,
  input  wire logic                  tx_ack,
  input  wire logic                  rx_done,
  input  wire logic [7:0]            rx_bytes,
  input  wire logic                  rx_ovf,
  input  wire logic                  frame_tick,
  input  wire logic                  frame_lsb,
  input  wire logic [NEP-1:0]        ep_en_in,
  input  wire logic [NEP-1:0]        ep_en_out,
  input  wire logic [NEP-1:0]        ep_iso_in,
  input  wire logic [NEP-1:0]        ep_iso_out,
  input  wire logic [NEP-1:0]        ep_dbl_in,
  input  wire logic [NEP-1:0]        ep_stall_in,
  input  wire logic [2*NEP-1:0]      ep_bps_in,
  input  wire logic [2*NEP-1:0]      ep_bps_out,
  input  wire logic                  mcu_wr,
  input  wire logic                  mcu_out,
  input  wire logic [2:0]            mcu_ep,
  input  wire logic                  mcu_y,
  input  wire logic                  mcu_busy,
  input  wire logic [7:0]            mcu_cnt,
  input  wire logic                  mcu_tgl_wr,
  input  wire logic                  mcu_tgl,
  input  wire logic                  mcu_ovf_clr,
  input  wire logic [NCH-1:0]        dma_en,
  input  wire logic [NCH-1:0]        dma_out_dir,
  input  wire logic [3*NCH-1:0]      dma_ep,
  input  wire logic [NCH-1:0]        aud_in_valid,
  input  wire logic [NCH-1:0]        aud_ready,
  output logic [NCH-1:0]             aud_out_valid_reg,
  output logic                       rsp_valid_reg,
  output uebm_pkg::uebm_rsp_e        rsp_code_reg,
  output logic                       rsp_buf_y_reg,
  output logic [7:0]                 rsp_count_reg,
  output logic [2*NEP-1:0]           in_busy_reg,
  output logic [2*NEP-1:0]           out_busy_reg,
  output logic [NEP-1:0]             in_tgl_reg,
  output logic [NEP-1:0]             in_ovf_reg,
  output logic [NEP-1:0]             out_ovf_reg,
  output logic [NEP-1:0]             ep_irq_reg,
  output logic                       frame_lsb_reg
);

  uebm_pkg::uebm_st_e st_reg;
  logic [2:0]         cur_ep_reg;
  logic               cur_y_reg;
  logic               cur_iso_reg;
  logic [7:0]         cnt_in_reg  [2*NEP];
  logic [7:0]         cnt_out_reg [2*NEP];
  logic [7:0]         rem_reg     [NCH];
  logic [7:0]         fill_reg    [NCH];
  logic [2*NEP-1:0]   in_set;
  logic [2*NEP-1:0]   in_clr;
  logic [2*NEP-1:0]   out_set;
  logic [2*NEP-1:0]   out_clr;
  logic [NCH-1:0]     dma_go_out;
  logic [NCH-1:0]     dma_act_in;
  logic               tx_fin;
  logic               rx_fin;
  logic               t_iso;
  logic               t_y;
  logic               t_busy;
  logic [NEP-1:0]     iso_in_ok;
  logic [NEP-1:0]     iso_out_ok;

  // Buffer slot index from endpoint and X/Y select
  function automatic int bidx(input logic [2:0] ep, input logic y);
    return int'({ep, y});
  endfunction

  // Samples to bytes
  function automatic logic [7:0] smp2byte(input logic [7:0] n, input logic [1:0] bps);
    logic [9:0] p;
    p = {2'h0, n} * ({8'h00, bps} + 10'h001);
    return p[7:0];
  endfunction

  // Bytes to samples
  function automatic logic [7:0] byte2smp(input logic [7:0] b, input logic [1:0] bps);
    logic [7:0] s;
    s = b;
    unique case (bps)
      uebm_pkg::BPS_1: s = b;
      uebm_pkg::BPS_2: s = b >> 1;
      uebm_pkg::BPS_3: s = b / uebm_pkg::DIV_3;
      uebm_pkg::BPS_4: s = b >> 2;
    endcase
    return s;
  endfunction

  function automatic logic [2:0] ch_ep(input logic [3*NCH-1:0] v, input int c);
    return v[c*uebm_pkg::EP_W +: uebm_pkg::EP_W];
  endfunction

  // Iso allowed only on endpoints 1..7
  always_comb
  begin
    iso_in_ok  = ep_iso_in;
    iso_out_ok = ep_iso_out;
    iso_in_ok[uebm_pkg::EP_CTRL]  = 1'b0;
    iso_out_ok[uebm_pkg::EP_CTRL] = 1'b0;
  end

  // Token decode; iso uses frame parity, double-buffered bulk uses toggle, other bulk uses X
  always_comb
  begin
    t_iso = iso_in_ok[tok_ep];
    if (t_iso)
      t_y = frame_lsb_reg;
    else if (ep_dbl_in[tok_ep])
      t_y = in_tgl_reg[tok_ep];
    else
      t_y = uebm_pkg::BUF_X;
    t_busy = in_busy_reg[bidx(tok_ep, t_y)];
  end

  assign tx_fin = (st_reg == uebm_pkg::ST_TX) && tx_end;
  assign rx_fin = (st_reg == uebm_pkg::ST_RX) && rx_done;

  // Frame parity
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      frame_lsb_reg <= uebm_pkg::BUF_X;
    else if (frame_tick)
      frame_lsb_reg <= frame_lsb;
  end

  // Transaction sequencer and reply
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg        <= uebm_pkg::ST_IDLE;
      cur_ep_reg    <= uebm_pkg::EP_CTRL;
      cur_y_reg     <= uebm_pkg::BUF_X;
      cur_iso_reg   <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_code_reg  <= uebm_pkg::RSP_NAK;
      rsp_buf_y_reg <= uebm_pkg::BUF_X;
      rsp_count_reg <= uebm_pkg::CNT_ZERO;
    end
    else
    begin
      rsp_valid_reg <= 1'b0;
      unique case (st_reg)
        uebm_pkg::ST_IDLE:
          if (tok_valid && tok_in && ep_en_in[tok_ep])
          begin
            rsp_valid_reg <= 1'b1;
            rsp_buf_y_reg <= t_y;
            cur_ep_reg    <= tok_ep;
            cur_y_reg     <= t_y;
            cur_iso_reg   <= t_iso;
            rsp_count_reg <= uebm_pkg::CNT_ZERO;
            if (ep_stall_in[tok_ep])
              rsp_code_reg <= uebm_pkg::RSP_STALL;
            else if (t_busy && t_iso)
              rsp_code_reg <= uebm_pkg::RSP_ZLP;
            else if (t_busy)
              rsp_code_reg <= uebm_pkg::RSP_NAK;
            else
            begin
              rsp_code_reg  <= uebm_pkg::RSP_DATA;
              rsp_count_reg <= t_iso ? smp2byte(cnt_in_reg[bidx(tok_ep, t_y)], ep_bps_in[tok_ep*2 +: 2])
                                     : cnt_in_reg[bidx(tok_ep, t_y)];
              st_reg        <= uebm_pkg::ST_TX;
            end
          end
          else if (tok_valid && !tok_in && ep_en_out[tok_ep] && iso_out_ok[tok_ep])
          begin
            cur_ep_reg  <= tok_ep;
            cur_y_reg   <= frame_lsb_reg;
            cur_iso_reg <= 1'b1;
            st_reg      <= uebm_pkg::ST_RX;
          end
        uebm_pkg::ST_TX:
          if (tx_end)
            st_reg <= uebm_pkg::ST_IDLE;
        uebm_pkg::ST_RX:
          if (rx_done)
            st_reg <= uebm_pkg::ST_IDLE;
        default:
          st_reg <= uebm_pkg::ST_IDLE;
      endcase
    end
  end

  // Set and clear requests for busy flags
  always_comb
  begin
    in_set     = '0;
    in_clr     = '0;
    out_set    = '0;
    out_clr    = '0;
    dma_go_out = '0;
    dma_act_in = '0;
    if (mcu_wr && mcu_out && mcu_busy)
      out_set[bidx(mcu_ep, mcu_y)] = 1'b1;
    if (mcu_wr && mcu_out && !mcu_busy)
      out_clr[bidx(mcu_ep, mcu_y)] = 1'b1;
    if (mcu_wr && !mcu_out && mcu_busy)
      in_set[bidx(mcu_ep, mcu_y)] = 1'b1;
    if (mcu_wr && !mcu_out && !mcu_busy)
      in_clr[bidx(mcu_ep, mcu_y)] = 1'b1;
    if (tx_fin && (cur_iso_reg || tx_ack))
      in_set[bidx(cur_ep_reg, cur_y_reg)] = 1'b1;
    if (rx_fin)
      out_set[bidx(cur_ep_reg, cur_y_reg)] = 1'b1;
    for (int c = 0; c < NCH; c++)
    begin
      dma_act_in[c] = dma_en[c] && !dma_out_dir[c] && iso_in_ok[ch_ep(dma_ep, c)];
      dma_go_out[c] = frame_tick && dma_en[c] && dma_out_dir[c] && iso_out_ok[ch_ep(dma_ep, c)]
                      && out_busy_reg[bidx(ch_ep(dma_ep, c), frame_lsb_reg)];
      if (dma_go_out[c])
        out_clr[bidx(ch_ep(dma_ep, c), frame_lsb_reg)] = 1'b1;
      if (frame_tick && dma_act_in[c])
        in_clr[bidx(ch_ep(dma_ep, c), ~frame_lsb_reg)] = 1'b1;
    end
  end

  // Busy flags, set wins over clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_busy_reg  <= '1;
      out_busy_reg <= '0;
    end
    else
    begin
      in_busy_reg  <= (in_busy_reg & ~in_clr) | in_set;
      out_busy_reg <= (out_busy_reg & ~out_clr) | out_set;
    end
  end

  // In data counts from firmware or in channels
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 2*NEP; i++)
        cnt_in_reg[i] <= uebm_pkg::CNT_ZERO;
    end
    else
    begin
      if (mcu_wr && !mcu_out)
        cnt_in_reg[bidx(mcu_ep, mcu_y)] <= mcu_cnt;
      for (int c = 0; c < NCH; c++)
        if (frame_tick && dma_act_in[c])
          cnt_in_reg[bidx(ch_ep(dma_ep, c), ~frame_lsb_reg)] <= fill_reg[c];
    end
  end

  // Out sample counts from received packets
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 2*NEP; i++)
        cnt_out_reg[i] <= uebm_pkg::CNT_ZERO;
    end
    else if (rx_fin)
      cnt_out_reg[bidx(cur_ep_reg, cur_y_reg)] <= byte2smp(rx_bytes, ep_bps_out[cur_ep_reg*2 +: 2]);
  end

  // Toggle bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      in_tgl_reg <= {NEP{uebm_pkg::TGL_INIT}};
    else
    begin
      if (mcu_tgl_wr)
        in_tgl_reg[mcu_ep] <= mcu_tgl;
      if (tx_fin && !cur_iso_reg && tx_ack)
        in_tgl_reg[cur_ep_reg] <= ~in_tgl_reg[cur_ep_reg];
    end
  end

  // Endpoint interrupt pulse, bulk only
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ep_irq_reg <= '0;
    else
    begin
      ep_irq_reg <= '0;
      if (tx_fin && !cur_iso_reg && tx_ack)
        ep_irq_reg[cur_ep_reg] <= 1'b1;
    end
  end

  // Overflow bits, set wins over clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_ovf_reg  <= '0;
      out_ovf_reg <= '0;
    end
    else
    begin
      if (mcu_ovf_clr && mcu_out)
        out_ovf_reg[mcu_ep] <= 1'b0;
      if (mcu_ovf_clr && !mcu_out)
        in_ovf_reg[mcu_ep] <= 1'b0;
      if (rx_fin && rx_ovf)
        out_ovf_reg[cur_ep_reg] <= 1'b1;
      for (int c = 0; c < NCH; c++)
        if (dma_act_in[c] && aud_in_valid[c] && fill_reg[c] == SMP_MAX)
          in_ovf_reg[ch_ep(dma_ep, c)] <= 1'b1;
    end
  end

  // Streaming channels
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aud_out_valid_reg <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        rem_reg[c]  <= uebm_pkg::CNT_ZERO;
        fill_reg[c] <= uebm_pkg::CNT_ZERO;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        aud_out_valid_reg[c] <= 1'b0;
        if (dma_go_out[c])
          rem_reg[c] <= cnt_out_reg[bidx(ch_ep(dma_ep, c), frame_lsb_reg)];
        else if (rem_reg[c] != uebm_pkg::CNT_ZERO && aud_ready[c])
        begin
          aud_out_valid_reg[c] <= 1'b1;
          rem_reg[c]           <= rem_reg[c] - uebm_pkg::CNT_ONE;
        end
        if (frame_tick && dma_act_in[c])
          fill_reg[c] <= uebm_pkg::CNT_ZERO;
        else if (dma_act_in[c] && aud_in_valid[c] && fill_reg[c] != SMP_MAX)
          fill_reg[c] <= fill_reg[c] + uebm_pkg::CNT_ONE;
      end
    end
  end

  sequence s_bulk_ack;
    tx_fin && !cur_iso_reg && tx_ack;
  endsequence

  sequence s_bulk_lost;
    tx_fin && !cur_iso_reg && !tx_ack;
  endsequence

  logic idle_tok;
  assign idle_tok = (st_reg == uebm_pkg::ST_IDLE) && tok_valid && tok_in && ep_en_in[tok_ep];

  a_nak_on_busy: assert property (@(posedge clk) disable iff (!resetn)
    idle_tok && !ep_stall_in[tok_ep] && t_busy && !t_iso |=> rsp_valid_reg && rsp_code_reg == uebm_pkg::RSP_NAK
      && st_reg == uebm_pkg::ST_IDLE)
    else $error("busy bulk token not answered by NAK");

  a_stall_reply: assert property (@(posedge clk) disable iff (!resetn)
    idle_tok && ep_stall_in[tok_ep] |=> rsp_code_reg == uebm_pkg::RSP_STALL)
    else $error("stalled endpoint not answered by STALL");

  a_iso_no_irq: assert property (@(posedge clk) disable iff (!resetn)
    (ep_irq_reg & iso_in_ok) == '0)
    else $error("interrupt raised on isochronous endpoint");

  a_ack_effects: assert property (@(posedge clk) disable iff (!resetn)
    s_bulk_ack |=> ep_irq_reg[$past(cur_ep_reg)] && in_tgl_reg[$past(cur_ep_reg)] != $past(in_tgl_reg[cur_ep_reg])
      ##1 !ep_irq_reg[$past(cur_ep_reg, 2)])
    else $error("bulk ACK did not toggle and interrupt once");

  a_noack_hold: assert property (@(posedge clk) disable iff (!resetn)
    s_bulk_lost and !mcu_tgl_wr |=> $stable(in_tgl_reg) && ep_irq_reg == '0)
    else $error("lost handshake changed endpoint state");

  a_iso_zlp: assert property (@(posedge clk) disable iff (!resetn)
    idle_tok && !ep_stall_in[tok_ep] && t_iso && t_busy |=> rsp_code_reg == uebm_pkg::RSP_ZLP
      && rsp_count_reg == uebm_pkg::CNT_ZERO)
    else $error("busy iso buffer did not send zero-length packet");

  a_out_busy_set: assert property (@(posedge clk) disable iff (!resetn)
    rx_fin |=> out_busy_reg[bidx($past(cur_ep_reg), $past(cur_y_reg))])
    else $error("iso out packet did not set busy flag");

  a_dbl_select: assert property (@(posedge clk) disable iff (!resetn)
    idle_tok && !t_iso && ep_dbl_in[tok_ep] |=> rsp_buf_y_reg == $past(in_tgl_reg[tok_ep]))
    else $error("double buffer select not following toggle");

  a_out_idle_dma: assert property (@(posedge clk) disable iff (!resetn)
    rem_reg[0] == uebm_pkg::CNT_ZERO && !dma_go_out[0] |=> !aud_out_valid_reg[0])
    else $error("channel streamed with no packet");

endmodule
`default_nettype wire

// ---- shared/uebm_pkg.sv ----
package uebm_pkg;

  localparam int         EP_W        = 3;
  localparam int         CNT_W       = 8;
  localparam int         BPS_W       = 2;
  localparam logic       BUF_X       = 1'h0;
  localparam logic       BUF_Y       = 1'h1;
  localparam logic       TGL_INIT    = 1'h0;
  localparam logic [2:0] EP_CTRL     = 3'h0;
  localparam logic [1:0] BPS_1       = 2'h0;
  localparam logic [1:0] BPS_2       = 2'h1;
  localparam logic [1:0] BPS_3       = 2'h2;
  localparam logic [1:0] BPS_4       = 2'h3;
  localparam logic [7:0] DIV_3       = 8'h03;
  localparam logic [7:0] CNT_ZERO    = 8'h00;
  localparam logic [7:0] CNT_ONE     = 8'h01;
  localparam logic [7:0] SMP_MAX_DEF = 8'hC0;

  typedef enum logic [1:0]
  {
    RSP_DATA,
    RSP_NAK,
    RSP_STALL,
    RSP_ZLP
  } uebm_rsp_e;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_TX,
    ST_RX
  } uebm_st_e;

endpackage

// ---- tb/uebm_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module uebm_host_model (
  input  wire logic       clk,
  output logic            tok_valid,
  output logic            tok_in,
  output logic [2:0]      tok_ep,
  output logic            tx_end,
  output logic            tx_ack,
  output logic            rx_done,
  output logic [7:0]      rx_bytes,
  output logic            rx_ovf
);
  initial
  begin
    {tok_valid, tok_in, tok_ep, tx_end, tx_ack, rx_done, rx_bytes, rx_ovf} = '0;
  end
  // Token phase; released lines go to inverted values
  task automatic token(input logic dir, input logic [2:0] ep);
    begin
      @(posedge clk);
      tok_valid <= 1'h1;
      tok_in    <= dir;
      tok_ep    <= ep;
      @(posedge clk);
      tok_valid <= 1'h0;
      tok_in    <= ~dir;
      tok_ep    <= ~ep;
    end
  endtask
  // End of a sent packet after a delay, with or without handshake
  task automatic handshake(input logic ack, input int gap);
    begin
      repeat (gap) @(posedge clk);
      @(posedge clk);
      tx_end <= 1'h1;
      tx_ack <= ack;
      @(posedge clk);
      tx_end <= 1'h0;
      tx_ack <= ~ack;
    end
  endtask
  // End of a received out packet after a delay
  task automatic packet(input logic [7:0] bytes, input logic ovf, input int gap);
    begin
      repeat (gap) @(posedge clk);
      @(posedge clk);
      rx_done  <= 1'h1;
      rx_bytes <= bytes;
      rx_ovf   <= ovf;
      @(posedge clk);
      rx_done  <= 1'h0;
      rx_bytes <= ~bytes;
      rx_ovf   <= ~ovf;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/test_usb_endpoint_buffer_manager.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_usb_endpoint_buffer_manager;
  localparam logic [7:0] SMAX = 8'h10;
  logic clk, resetn, tok_valid, tok_in, tx_end, tx_ack, rx_done, rx_ovf, frame_tick, frame_lsb;
  logic mcu_wr, mcu_out, mcu_y, mcu_busy, mcu_tgl_wr, mcu_tgl, mcu_ovf_clr;
  logic rsp_valid_reg, rsp_buf_y_reg, frame_lsb_reg;
  logic [2:0] tok_ep, mcu_ep, rsp_hdr;
  logic [7:0] rx_bytes, mcu_cnt, rsp_count_reg, ep_en_in, ep_en_out, ep_iso_in, ep_iso_out;
  logic [7:0] ep_dbl_in, ep_stall_in, in_tgl_reg, in_ovf_reg, out_ovf_reg, ep_irq_reg, c1, c2, b;
  logic [15:0] ep_bps_in, ep_bps_out, in_busy_reg, out_busy_reg;
  logic [3:0] dma_en, dma_out_dir, aud_in_valid, aud_ready, aud_out_valid_reg;
  logic [11:0] dma_ep, rsp_all;
  uebm_pkg::uebm_rsp_e rsp_code_reg;
  int num_errors, n_compared, pulses, irq_iso, ich, och, bi, bo, n, m;

  assign rsp_hdr = {rsp_valid_reg, rsp_code_reg};
  assign rsp_all = {rsp_valid_reg, rsp_code_reg, rsp_buf_y_reg, rsp_count_reg};

  uebm_core #(.SMP_MAX(SMAX)) dut (
    .clk, .resetn, .tok_valid, .tok_in, .tok_ep, .tx_end, .tx_ack, .rx_done, .rx_bytes, .rx_ovf,
    .frame_tick, .frame_lsb, .ep_en_in, .ep_en_out, .ep_iso_in, .ep_iso_out, .ep_dbl_in, .ep_stall_in,
    .ep_bps_in, .ep_bps_out, .mcu_wr, .mcu_out, .mcu_ep, .mcu_y, .mcu_busy, .mcu_cnt, .mcu_tgl_wr,
    .mcu_tgl, .mcu_ovf_clr, .dma_en, .dma_out_dir, .dma_ep, .aud_in_valid, .aud_ready,
    .aud_out_valid_reg, .rsp_valid_reg, .rsp_code_reg, .rsp_buf_y_reg, .rsp_count_reg, .in_busy_reg,
    .out_busy_reg, .in_tgl_reg, .in_ovf_reg, .out_ovf_reg, .ep_irq_reg, .frame_lsb_reg
  );

  uebm_host_model host (
    .clk, .tok_valid, .tok_in, .tok_ep, .tx_end, .tx_ack, .rx_done, .rx_bytes, .rx_ovf
  );

  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Audio port stalls at random; pulse and interrupt tallies
  always @(posedge clk)
  begin
    aud_ready <= 4'($urandom);
    pulses    <= pulses + int'(aud_out_valid_reg[och]);
    if (|(ep_irq_reg & ep_iso_in & 8'hFE))
      irq_iso <= irq_iso + 1;
  end

  function automatic logic [2:0] hdr(input uebm_pkg::uebm_rsp_e c);
    return {1'h1, c};
  endfunction

  function automatic logic [11:0] data_rsp(input logic y, input logic [7:0] c);
    return {1'h1, uebm_pkg::RSP_DATA, y, c};
  endfunction

  function automatic logic [7:0] iso_bytes(input int smp, input int code);
    return 8'(smp * (code + 1));
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        num_errors++;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task automatic in_tok(input logic [2:0] ep);
    begin
      host.token(1'h1, ep);
      #1;
    end
  endtask

  task automatic fw(input logic o, input logic [2:0] ep, input logic y, input logic bsy, input logic [7:0] c);
    begin
      @(posedge clk);
      mcu_wr   <= 1'h1;
      mcu_out  <= o;
      mcu_ep   <= ep;
      mcu_y    <= y;
      mcu_busy <= bsy;
      mcu_cnt  <= c;
      @(posedge clk);
      mcu_wr   <= 1'h0;
    end
  endtask

  task automatic frame(input logic l);
    begin
      @(posedge clk);
      frame_tick <= 1'h1;
      frame_lsb  <= l;
      @(posedge clk);
      frame_tick <= 1'h0;
      #1;
    end
  endtask

  task automatic feed(input int k);
    begin
      repeat (k)
      begin
        @(posedge clk);
        aud_in_valid <= 4'(1 << ich);
        @(posedge clk);
        aud_in_valid <= 4'h0;
      end
      #1;
    end
  endtask

  initial
  begin
    #50000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    {resetn, mcu_wr, mcu_out, mcu_y, mcu_busy, mcu_tgl_wr, mcu_tgl, mcu_ovf_clr, frame_tick, frame_lsb} = '0;
    {mcu_ep, mcu_cnt, ep_bps_in, ep_bps_out, dma_en, dma_out_dir, dma_ep, aud_in_valid} = '0;
    {num_errors, n_compared, pulses, irq_iso, och} = '0;
    {ep_en_in, ep_en_out, ep_iso_in, ep_iso_out, ep_dbl_in, ep_stall_in} = {8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'h02, 8'h00};
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    #1;
    check(in_busy_reg, 16'hFFFF);
    check(out_busy_reg, 16'h0000);
    void'($urandom(60));
    ich = $urandom % 4;
    och = (ich + 1) % 4;
    @(posedge clk);
    ep_bps_in   <= 16'($urandom);
    ep_bps_out  <= 16'($urandom);
    dma_en      <= 4'((1 << ich) | (1 << och));
    dma_out_dir <= 4'(1 << och);
    dma_ep      <= 12'((2 << (3 * ich)) | (3 << (3 * och)));
    for (int e = 1; e < 8; e++)
    begin
      in_tok(3'(e));
      check(rsp_hdr, hdr(uebm_pkg::RSP_ZLP));
      host.handshake(1'h0, e % 3);
    end
    $display("iso endpoint sweep done");
    @(posedge clk);
    ep_iso_in  <= 8'hFC;
    mcu_tgl_wr <= 1'h1;
    mcu_ep     <= 3'h1;
    mcu_tgl    <= uebm_pkg::TGL_INIT;
    @(posedge clk);
    mcu_tgl_wr <= 1'h0;
    c1 = 8'($urandom);
    c2 = 8'($urandom);
    fw(1'h0, 3'h1, uebm_pkg::BUF_X, 1'h0, c1);
    in_tok(3'h1);
    check(rsp_all, data_rsp(uebm_pkg::BUF_X, c1));
    host.handshake(1'h0, 2);
    #1;
    check({in_busy_reg[2], in_tgl_reg[1], ep_irq_reg[1]}, 3'h0);
    in_tok(3'h1);
    check(rsp_all, data_rsp(uebm_pkg::BUF_X, c1));
    host.handshake(1'h1, 0);
    #1;
    check({in_busy_reg[2], in_tgl_reg[1], ep_irq_reg[1]}, 3'h7);
    in_tok(3'h1);
    check(rsp_hdr, hdr(uebm_pkg::RSP_NAK));
    fw(1'h0, 3'h1, uebm_pkg::BUF_Y, 1'h0, c2);
    in_tok(3'h1);
    check(rsp_all, data_rsp(uebm_pkg::BUF_Y, c2));
    host.handshake(1'h1, 3);
    #1;
    check({in_busy_reg[3], in_tgl_reg[1]}, 2'h2);
    @(posedge clk);
    ep_stall_in <= 8'h02;
    in_tok(3'h1);
    check(rsp_hdr, hdr(uebm_pkg::RSP_STALL));
    $display("bulk in test done");
    bi = int'(ep_bps_in[5:4]);
    n = 1 + $urandom % int'(SMAX);
    feed(n);
    frame(1'h1);
    check(in_busy_reg[5], 1'h0);
    in_tok(3'h2);
    check(rsp_all, data_rsp(uebm_pkg::BUF_Y, iso_bytes(n, bi)));
    host.handshake(1'h0, 1);
    #1;
    check(in_busy_reg[5], 1'h1);
    in_tok(3'h2);
    check(rsp_hdr, hdr(uebm_pkg::RSP_ZLP));
    host.handshake(1'h0, 0);
    feed(int'(SMAX));
    check(in_ovf_reg[2], 1'h0);
    feed(1);
    check(in_ovf_reg[2], 1'h1);
    $display("iso in test done");
    bo = int'(ep_bps_out[7:6]);
    m = 1 + $urandom % int'(SMAX);
    b = iso_bytes(m, bo) + 8'($urandom % (bo + 1));
    host.token(1'h0, 3'h3);
    host.packet(b, 1'h0, 2);
    #1;
    check({out_busy_reg[7], out_ovf_reg[3]}, 2'h2);
    pulses = 0;
    frame(1'h0);
    check(out_busy_reg[7], 1'h0);
    repeat (100) @(posedge clk);
    #1;
    check(16'(pulses), 16'(m));
    pulses = 0;
    frame(1'h1);
    repeat (60) @(posedge clk);
    #1;
    check(16'(pulses), 16'h0000);
    host.token(1'h0, 3'h3);
    host.packet(8'(bo + 1), 1'h1, 0);
    #1;
    check(out_ovf_reg[3], 1'h1);
    @(posedge clk);
    mcu_ovf_clr <= 1'h1;
    mcu_out     <= 1'h1;
    mcu_ep      <= 3'h3;
    @(posedge clk);
    mcu_ovf_clr <= 1'h0;
    #1;
    check({in_ovf_reg[2], out_ovf_reg[3]}, 2'h2);
    host.token(1'h0, 3'h4);
    host.packet(8'h01, 1'h0, 0);
    frame(1'h0);
    check(frame_lsb_reg, 1'h0);
    check(out_busy_reg[9:8], 2'h2);
    fw(1'h1, 3'h4, uebm_pkg::BUF_Y, 1'h0, 8'h00);
    #1;
    check(out_busy_reg[9:8], 2'h0);
    check(16'(irq_iso), 16'h0000);
    $display("iso out test done");
    print_verdict();
  end
endmodule
`default_nettype wire
